// ### pll_divider_phase_select.sv
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
module pll_divider_phase_select (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        write_strobe,
  input  wire logic        read_strobe,
  input  wire logic [8:0]  hardwired_in,
  input  wire logic [3:0]  external_in,
  input  wire logic [3:0]  core_in,
  output logic [31:0]      rdata,
  output logic             global_output_a,
  output logic             global_output_b,
  output logic             global_output_c
);
  localparam int AW = pll_cfg_pkg::ACC_W;

  typedef struct packed {
    logic [6:0]      ref_div;
    logic [6:0]      fb_div;
    logic [2:0][4:0] out_div;
    logic [2:0][2:0] out_sel;
    logic [3:0][5:0] src_cfg;
    logic [3:0]      picked;
    logic [AW-1:0]   acc;
    logic [1:0]      phase;
    logic            vco_tick;
    logic [2:0]      glob;
    logic [31:0]     rdata;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;

  logic       ref_div_tick;
  logic       fb_tick;
  logic [3:0] taps;
  logic [2:0] div_in;
  logic [2:0] div_out;

  // Source select shared by loop reference and the three delay-only paths
  function automatic logic pick_source(input logic [5:0] cfg, input logic [8:0] hw,
                                       input logic ext, input logic core);
    logic r;
    r = 1'b0;
    if (cfg[1:0] == pll_cfg_pkg::SRC_HARDWIRED) begin
      // Out-of-range pin index reads as idle; placement is software's job
      if (cfg[5:2] <= pll_cfg_pkg::HW_INDEX_MAX) begin
        r = hw[cfg[5:2]];
      end
    end else if (cfg[1:0] == pll_cfg_pkg::SRC_EXTERNAL) begin
      r = ext;
    end else if (cfg[1:0] == pll_cfg_pkg::SRC_CORE) begin
      r = core;
    end
    return r;
  endfunction

  // Tap order in the selector is 0, 270, 180, 90 degrees
  function automatic logic route_tap(input logic [2:0] sel, input logic [3:0] t,
                                     input logic fb);
    logic r;
    r = 1'b0;
    case (sel)
      pll_cfg_pkg::SEL_FEEDBACK: r = fb;
      pll_cfg_pkg::SEL_TAP_0:    r = t[0];
      pll_cfg_pkg::SEL_TAP_270:  r = t[3];
      pll_cfg_pkg::SEL_TAP_180:  r = t[2];
      pll_cfg_pkg::SEL_TAP_90:   r = t[1];
      default:                   r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] denom(input logic [6:0] in_div, input logic [4:0] o_div);
    logic [12:0] p;
    p = ({6'h00, in_div} + 13'h0001) * ({8'h00, o_div} + 13'h0001);
    return {19'h00000, p};
  endfunction

  always_comb begin
    logic [AW:0] sum;
    sum = '0;
    next_s = s;
    next_s.rdata = '0;
    if (write_strobe) begin
      if (addr == pll_cfg_pkg::OFS_DIVIDE) begin
        next_s.ref_div = wdata[pll_cfg_pkg::REF_DIV_POS +: 7];
        next_s.fb_div  = wdata[pll_cfg_pkg::FB_DIV_POS +: 7];
        for (int i = 0; i < 3; i++) begin
          next_s.out_div[i] = wdata[pll_cfg_pkg::OUT_DIV_POS + i*pll_cfg_pkg::OUT_DIV_STEP +: 5];
        end
      end else if (addr == pll_cfg_pkg::OFS_SELECT) begin
        for (int i = 0; i < 3; i++) begin
          next_s.out_sel[i] = wdata[i*pll_cfg_pkg::SEL_STEP +: 3];
        end
      end else if (addr == pll_cfg_pkg::OFS_SOURCE) begin
        for (int i = 0; i < 4; i++) begin
          next_s.src_cfg[i] = wdata[i*pll_cfg_pkg::SRC_STEP +: 6];
        end
      end
    end
    if (read_strobe) begin
      if (addr == pll_cfg_pkg::OFS_DIVIDE) begin
        next_s.rdata = {1'b0, s.out_div, 1'b0, s.fb_div, 1'b0, s.ref_div};
      end else if (addr == pll_cfg_pkg::OFS_SELECT) begin
        next_s.rdata = {23'h000000, s.out_sel};
      end else if (addr == pll_cfg_pkg::OFS_SOURCE) begin
        next_s.rdata = {8'h00, s.src_cfg};
      end else if (addr == pll_cfg_pkg::OFS_RATIO) begin
        next_s.rdata = {24'h000000, {1'b0, s.fb_div} + 8'h01};
      end else if (addr == pll_cfg_pkg::OFS_DENOM_A) begin
        next_s.rdata = denom(s.ref_div, s.out_div[0]);
      end else if (addr == pll_cfg_pkg::OFS_DENOM_B) begin
        next_s.rdata = denom(s.ref_div, s.out_div[1]);
      end else if (addr == pll_cfg_pkg::OFS_DENOM_C) begin
        next_s.rdata = denom(s.ref_div, s.out_div[2]);
      end else if (addr == pll_cfg_pkg::OFS_STATUS) begin
        for (int i = 0; i < 3; i++) begin
          next_s.rdata[i] = (s.out_sel[i] == 3'h1) || (s.out_sel[i] == 3'h3);
        end
        next_s.rdata[3] = (s.acc != '0);
        next_s.rdata[5:4] = s.phase;
      end
    end
    for (int i = 0; i < 4; i++) begin
      next_s.picked[i] = pick_source(s.src_cfg[i], hardwired_in, external_in[i], core_in[i]);
    end
    // Oscillator runs at four times the tap rate so each tap is a quarter period apart.
    // Credits saturate: a reference too fast for the clock loses ticks, not state.
    sum = {1'b0, s.acc};
    if (ref_div_tick) begin
      sum = sum + (AW+1)'({({1'b0, s.fb_div} + 8'h01), 2'b00});
    end
    next_s.vco_tick = 1'b0;
    if (s.acc != '0) begin
      next_s.vco_tick = 1'b1;
      sum = sum - (AW+1)'(1);
    end
    next_s.acc = sum[AW] ? {AW{1'b1}} : sum[AW-1:0];
    if (s.vco_tick) begin
      next_s.phase = s.phase + 2'h1;
    end
    for (int i = 0; i < 3; i++) begin
      if (s.out_sel[i] == pll_cfg_pkg::SEL_BYPASS) begin
        next_s.glob[i] = s.picked[i+1];
      end else if (s.out_sel[i] == 3'h1 || s.out_sel[i] == 3'h3) begin
        next_s.glob[i] = 1'b0;
      end else begin
        next_s.glob[i] = div_out[i];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.ref_div <= pll_cfg_pkg::REF_DIV_RESET;
      s.fb_div  <= pll_cfg_pkg::FB_DIV_RESET;
      s.out_div <= {3{pll_cfg_pkg::OUT_DIV_RESET}};
      s.out_sel <= {3{pll_cfg_pkg::SEL_RESET}};
      s.src_cfg <= {4{pll_cfg_pkg::SRC_RESET}};
    end else begin
      s <= next_s;
    end
  end

  generate
    for (genvar k = 0; k < 4; k++) begin : g_tap
      assign taps[k] = s.vco_tick && (s.phase == 2'(k));
    end
  endgenerate

  tick_divider #(.W(7)) ref_divider (
    .clock          (clock),
    .rst            (rst),
    .tick_in        (s.picked[0]),
    .divide_setting (s.ref_div),
    .tick_out       (ref_div_tick)
  );

  // Feedback closes on the 0 degree tap, so its rate equals the divided reference
  tick_divider #(.W(7)) fb_divider (
    .clock          (clock),
    .rst            (rst),
    .tick_in        (taps[0]),
    .divide_setting (s.fb_div),
    .tick_out       (fb_tick)
  );

  generate
    for (genvar i = 0; i < 3; i++) begin : g_out
      assign div_in[i] = route_tap(s.out_sel[i], taps, fb_tick);
      tick_divider #(.W(5)) out_divider (
        .clock          (clock),
        .rst            (rst),
        .tick_in        (div_in[i]),
        .divide_setting (s.out_div[i]),
        .tick_out       (div_out[i])
      );
    end
  endgenerate

  assign rdata           = s.rdata;
  assign global_output_a = s.glob[0];
  assign global_output_b = s.glob[1];
  assign global_output_c = s.glob[2];
endmodule

// ### pll_cfg_pkg.sv
// Behaviour
// - Reference divider divides by its 7-bit setting plus one, 1 to 128.
// - Feedback divider multiplies by its 7-bit setting plus one, 1 to 128.
// - Each output divider divides by its 5-bit setting plus one, 1 to 32.
// - Selector code 0 bypasses loop; source tick goes straight to global output.
// - Selector code 2 drives the output from the feedback divider.
// - Codes 4,5,6,7 pick oscillator taps at 0, 270, 180, 90 degrees.
// - Loop reference and three paths pick hardwired, external or core source.
package pll_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ACC_W  = 11;

  localparam logic [7:0] OFS_DIVIDE = 8'h00;
  localparam logic [7:0] OFS_SELECT = 8'h04;
  localparam logic [7:0] OFS_SOURCE = 8'h08;
  localparam logic [7:0] OFS_RATIO  = 8'h0c;
  localparam logic [7:0] OFS_DENOM_A = 8'h10;
  localparam logic [7:0] OFS_DENOM_B = 8'h14;
  localparam logic [7:0] OFS_DENOM_C = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;

  localparam int REF_DIV_POS = 0;
  localparam int FB_DIV_POS  = 8;
  localparam int OUT_DIV_POS = 16;
  localparam int OUT_DIV_STEP = 5;
  localparam int SEL_STEP     = 3;
  localparam int SRC_STEP     = 6;

  localparam logic [6:0] REF_DIV_RESET = 7'h00;
  localparam logic [6:0] FB_DIV_RESET  = 7'h00;
  localparam logic [4:0] OUT_DIV_RESET = 5'h00;
  localparam logic [2:0] SEL_RESET     = 3'h0;
  localparam logic [5:0] SRC_RESET     = 6'h00;

  localparam logic [2:0] SEL_BYPASS   = 3'h0;
  localparam logic [2:0] SEL_FEEDBACK = 3'h2;
  localparam logic [2:0] SEL_TAP_0    = 3'h4;
  localparam logic [2:0] SEL_TAP_270  = 3'h5;
  localparam logic [2:0] SEL_TAP_180  = 3'h6;
  localparam logic [2:0] SEL_TAP_90   = 3'h7;

  localparam logic [1:0] SRC_HARDWIRED = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL  = 2'h1;
  localparam logic [1:0] SRC_CORE      = 2'h2;
  localparam int HARDWIRED_COUNT = 9;
  localparam logic [3:0] HW_INDEX_MAX = 4'h8;
endpackage

// ### tick_divider.sv
`timescale 1ns/1ns
module tick_divider #(
  parameter int W = 7
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] divide_setting,
  output logic              tick_out
);
  typedef struct packed {
    logic [W-1:0] count;
    logic         out;
  } div_state_t;

  div_state_t s;
  div_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.out = 1'b0;
    if (tick_in) begin
      // Divisor is setting plus one; setting 0 passes every tick
      if (s.count >= divide_setting) begin
        next_s.count = '0;
        next_s.out = 1'b1;
      end else begin
        next_s.count = s.count + W'(1);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_out = s.out;
endmodule

// ### pll_divider_phase_select_checker.sv
`timescale 1ns/1ns
module pll_divider_phase_select_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        write_strobe,
  input wire logic        read_strobe,
  input wire logic [8:0]  hardwired_in,
  input wire logic [3:0]  external_in,
  input wire logic [31:0] rdata,
  input wire logic        global_output_a,
  input wire logic        global_output_b
);
  logic [31:0] div;
  logic [31:0] sel;
  logic [31:0] src;
  logic [8:0]  hw1;
  logic [8:0]  hw2;
  logic [3:0]  ex1;
  logic [3:0]  ex2;
  logic [2:0]  quiet;
  // Quiet gates path checks: stale ticks may drain after a write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div   <= '0;
      sel   <= '0;
      src   <= '0;
      quiet <= '0;
    end else begin
      if (write_strobe && addr == pll_cfg_pkg::OFS_DIVIDE) div <= wdata & 32'h7fff7f7f;
      if (write_strobe && addr == pll_cfg_pkg::OFS_SELECT) sel <= wdata & 32'h1ff;
      if (write_strobe && addr == pll_cfg_pkg::OFS_SOURCE) src <= wdata & 32'hffffff;
      quiet <= write_strobe ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
    end
  end
  always_ff @(posedge clock) begin
    hw1 <= hardwired_in;
    hw2 <= hw1;
    ex1 <= external_in;
    ex2 <= ex1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_idle; !$past(read_strobe) |-> rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata set with no read");
  property p_unmapped; read_strobe && addr > 8'h1c |=> rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_readback; read_strobe && addr == 8'h00 |=> rdata == div; endproperty
  a_readback: assert property (p_readback) else $error("divide word readback");
  property p_ratio; read_strobe && addr == 8'h0c |=> rdata[7:0] == 8'(div[14:8]) + 8'h01;
  endproperty
  a_ratio: assert property (p_ratio) else $error("feedback divisor wrong");
  property p_denom;
    read_strobe && addr == 8'h10 |=> rdata == (32'(div[6:0]) + 1) * (32'(div[20:16]) + 1);
  endproperty
  a_denom: assert property (p_denom) else $error("input times output divisor wrong");
  property p_bypass_a;
    quiet == 3'h7 && sel[2:0] == 3'h0 && src[7:6] == 2'h0 && src[11:8] < 4'h9
      |-> global_output_a == hw2[src[11:8]];
  endproperty
  a_bypass_a: assert property (p_bypass_a) else $error("bypass path A not 2 cycles");
  property p_bypass_b;
    quiet == 3'h7 && sel[5:3] == 3'h0 && src[13:12] == 2'h1 |-> global_output_b == ex2[2];
  endproperty
  a_bypass_b: assert property (p_bypass_b) else $error("external bypass B wrong");
  property p_reserved; quiet == 3'h7 && sel[0] && !sel[2] |-> !global_output_a; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved selector drives A");
  property p_status;
    read_strobe && addr == 8'h1c
      |=> rdata[2:0] == {sel[6] & ~sel[8], sel[3] & ~sel[5], sel[0] & ~sel[2]};
  endproperty
  a_status: assert property (p_status) else $error("reserved flags wrong");
endmodule

// ### pll_source_model.sv
`timescale 1ns/1ns
module pll_source_model (
  input  wire logic       clock,
  input  wire logic       rst,
  output logic      [8:0] hardwired_in,
  output logic      [3:0] core_in
);
  logic [31:0] cyc;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cyc <= '0;
    end else begin
      cyc <= cyc + 32'h1;
    end
  end
  // Index i ticks every 16-i cycles; group A index 0 feeds the loop
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      hardwired_in[i] = (cyc % (16 - i)) == 0;
    end
    core_in = {4{cyc[2:0] == 3'h0}};
  end
endmodule

// ### pll_divider_phase_select_test.sv
`timescale 1ns/1ns
module pll_divider_phase_select_test;
  logic        clock;
  logic        rst;
  logic        write_strobe;
  logic        read_strobe;
  logic        pend;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] seed;
  logic [31:0] d;
  logic [8:0]  hardwired_in;
  logic [3:0]  external_in;
  logic [3:0]  core_in;
  logic        global_output_a;
  logic        global_output_b;
  logic        global_output_c;
  logic [31:0] notes [$];
  int          bad_count;
  int          checks_done;
  int          cycles;
  int          na;
  int          nc;
  logic [31:0] case_div [8] = '{32'h0, 32'h10100, 32'h10100, 32'h10100, 32'h30301, 32'h10100,
                                32'h0, 32'h0};
  logic [2:0]  case_sel [8] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2, 3'h1, 3'h3};
  int          case_exp [8] = '{32, 26, 26, 26, 13, 13, 0, 0};
  pll_divider_phase_select pll_divider_phase_select_inst (.clock(clock), .rst(rst),
    .addr(addr), .wdata(wdata), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .hardwired_in(hardwired_in), .external_in(external_in), .core_in(core_in),
    .rdata(rdata), .global_output_a(global_output_a), .global_output_b(global_output_b),
    .global_output_c(global_output_c));
  pll_source_model pll_source_model_inst (.clock(clock), .rst(rst),
    .hardwired_in(hardwired_in), .core_in(core_in));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic conclude();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic near(input string n, input int exp, input int got);
    checks_done++;
    if (got > exp + 1 || got + 1 < exp) begin
      $display("BAD %s expected %0d seen %0d", n, exp, got);
      bad_count++;
    end
  endtask
  // Strobes are only raised here; idle drops them so no step assigns twice
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    write_strobe <= 1'b1;
    read_strobe <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    notes.push_back(exp);
    addr <= a;
    write_strobe <= 1'b0;
    read_strobe <= 1'b1;
    @(posedge clock);
  endtask
  task automatic idle();
    write_strobe <= 1'b0;
    read_strobe <= 1'b0;
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    cycles++;
    seed <= xs(seed);
    external_in <= seed[3:0];
    if (pend && rdata !== notes[0]) begin
      $display("BAD rdata expected %0h seen %0h", notes[0], rdata);
      bad_count++;
    end
    if (pend) begin
      checks_done++;
      void'(notes.pop_front());
    end
    pend <= read_strobe;
    // Tick counts below are ints and would hide an unknown output
    if ($isunknown({global_output_a, global_output_b, global_output_c})) begin
      $display("BAD global_output expected known seen %b",
               {global_output_a, global_output_b, global_output_c});
      bad_count++;
    end
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    {rst, pend, write_strobe, read_strobe, addr, wdata, external_in} = '1;
    {pend, write_strobe, read_strobe, addr, wdata, external_in} = '0;
    seed = 32'h35;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(8'h00, 0);
    rd(8'h04, 0);
    rd(8'h0c, 1);
    rd(8'h20, 0);
    wr(8'h0c, 32'hff);
    rd(8'h0c, 1);
    $display("reset and refusal test done");
    for (int i = 0; i < 4; i++) begin
      d = seed & 32'h7fff7f7f;
      wr(8'h00, d);
      rd(8'h00, d);
      rd(8'h0c, 32'(d[14:8]) + 1);
      rd(8'h10, (32'(d[6:0]) + 1) * (32'(d[20:16]) + 1));
      rd(8'h18, (32'(d[6:0]) + 1) * (32'(d[30:26]) + 1));
    end
    $display("divider test done");
    // Reset also clears the divide word and any credits left by the random feedback settings
    idle();
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h1);
    rd(8'h10, 32'h1);
    $display("mid-run reset test done");
    wr(8'h08, 32'h081300);
    rd(8'h08, 32'h081300);
    for (int k = 0; k < 8; k++) begin
      // Loop reference off so credits drain and tap phase settles at zero
      wr(8'h08, 32'h081303);
      wr(8'h00, case_div[k]);
      wr(8'h04, {29'h0, case_sel[k]});
      idle();
      repeat (40) @(posedge clock);
      rd(8'h1c, {31'h0, case_sel[k][0] & ~case_sel[k][2]});
      wr(8'h08, 32'h081300);
      idle();
      repeat (64) @(posedge clock);
      na = 0;
      nc = 0;
      repeat (416) begin
        @(posedge clock);
        na += global_output_a;
        nc += global_output_c;
      end
      near("out_a", case_exp[k], na);
      near("out_c", 52, nc);
      $display("selector case %0d done", k);
    end
    idle();
    @(posedge clock);
    conclude();
  end
endmodule
bind pll_divider_phase_select pll_divider_phase_select_checker checker_inst (.clock(clock),
  .rst(rst), .addr(addr), .wdata(wdata), .write_strobe(write_strobe),
  .read_strobe(read_strobe), .hardwired_in(hardwired_in), .external_in(external_in),
  .rdata(rdata), .global_output_a(global_output_a), .global_output_b(global_output_b));
